// *** src/xcvr_params.svh ***
`ifndef XCVR_PARAMS_SVH
`define XCVR_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define XCVR_OFS_CTRL 8'h00
`define XCVR_OFS_STORE 8'h04
`define XCVR_OFS_CAPTURE 8'h08
`define XCVR_OFS_STATUS 8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define XCVR_CTRL_ENABLE_N 0
`define XCVR_CTRL_DIR 1
`define XCVR_CTRL_SEL_AB 2
`define XCVR_CTRL_SEL_BA 3
`define XCVR_STORE_A_LSB 0
`define XCVR_STORE_B_LSB 8
`define XCVR_CAP_VALID 31
`define XCVR_STAT_OVERFLOW 0
`define XCVR_STAT_PENDING 1

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define XCVR_CTRL_RESET 4'h1
`define XCVR_DATA_W 8
`define XCVR_BUF_DEPTH 2
`define XCVR_RESP_OKAY 2'h0
`define XCVR_RESP_SLVERR 2'h2

`endif

// *** src/xcvr_pkg.sv ***
`default_nettype none

`include "xcvr_params.svh"

package xcvr_pkg;

  // ****************************************************************
  // Control word and capture snapshot
  // ****************************************************************
  typedef struct packed {
    logic sel_ba;
    logic sel_ab;
    logic dir;
    logic enable_n;
  } ctrl_t;

  typedef struct packed {
    logic b_new;
    logic a_new;
    logic [`XCVR_DATA_W-1:0] b_data;
    logic [`XCVR_DATA_W-1:0] a_data;
  } cap_entry_t;

  // Bus pin group: value and drive enable (low while driving)
  typedef struct packed {
    logic [`XCVR_DATA_W-1:0] data;
    logic oe_n;
  } bus_drive_t;

endpackage : xcvr_pkg

`default_nettype wire

// *** src/xcvr_buffer.sv ***
`default_nettype none

module xcvr_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  // Clock, reset, freeze
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("xcvr_buffer: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic do_push;
  logic do_pop;

  // Handshakes and next pointers
  always_comb begin
    do_push = i_in_valid && o_in_ready;
    do_pop = o_out_valid && i_out_ready;
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointer and count registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage entries, written only on a push
  always_ff @(posedge i_core_clk) begin
    if (i_ce && do_push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Honest full and empty from the count register
  assign o_in_ready = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

endmodule : xcvr_buffer

`default_nettype wire

// *** src/octal_bus_transceiver_register.sv ***
// Contract
// - Each rising edge of A capture clock stores bus A into A register.
// - Each rising edge of B capture clock stores bus B into B register.
// - Capture is never disabled, even while both buses are isolated.
// - Bus driving depends only on enable and direction.
// - Enable high isolates both buses; registers hold without clock edges.
// - Enable low, direction low, B-to-A select low: live B drives A.
// - Enable low, direction low, B-to-A select high: B register drives A.
// - Enable low, direction high, A-to-B select low: live A drives B.
// - Enable low, direction high, A-to-B select high: A register drives B.
// - Switching between live and stored data gives no glitch.
// - Select low chooses live data, select high chooses stored data.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none

`include "xcvr_params.svh"

module octal_bus_transceiver_register #(
  parameter int BUF_DEPTH = `XCVR_BUF_DEPTH
) (
  // Clock, reset, freeze
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Capture clock pins
  input wire logic i_a_capture_clock,
  input wire logic i_b_capture_clock,
  // Bus A pins
  input wire logic [`XCVR_DATA_W-1:0] i_bus_a,
  output logic [`XCVR_DATA_W-1:0] o_bus_a,
  output logic o_bus_a_oe_n,
  // Bus B pins
  input wire logic [`XCVR_DATA_W-1:0] i_bus_b,
  output logic [`XCVR_DATA_W-1:0] o_bus_b,
  output logic o_bus_b_oe_n,
  // AXI4-Lite write address and data
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // AXI4-Lite write response
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp
);

  import xcvr_pkg::*;

  localparam int DW = `XCVR_DATA_W;
  localparam int CW = $bits(cap_entry_t);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
    $error("octal_bus_transceiver_register: bad BUF_DEPTH");
  end

  // ****************************************************************
  // Pin synchronisers and capture clock edge detection
  // ****************************************************************
  logic [DW-1:0] a_meta, a_live, b_meta, b_live;
  logic [1:0] clk_meta, clk_sync, clk_prev;
  logic a_rise, b_rise;

  // Two flops per pin before any logic looks at it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      a_meta <= '0;
      a_live <= '0;
      b_meta <= '0;
      b_live <= '0;
      clk_meta <= '0;
      clk_sync <= '0;
      clk_prev <= '0;
    end else if (i_ce) begin
      a_meta <= i_bus_a;
      a_live <= a_meta;
      b_meta <= i_bus_b;
      b_live <= b_meta;
      clk_meta <= {i_b_capture_clock, i_a_capture_clock};
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // Rising edges seen after synchronisation
  assign a_rise = clk_sync[0] && !clk_prev[0];
  assign b_rise = clk_sync[1] && !clk_prev[1];

  // ****************************************************************
  // Storage registers
  // ****************************************************************
  logic [DW-1:0] a_store, b_store, next_a_store, next_b_store;

  // Capture regardless of enable, direction or select
  always_comb begin
    next_a_store = a_rise ? a_live : a_store;
    next_b_store = b_rise ? b_live : b_store;
  end

  // Contents held while no edge arrives
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      a_store <= '0;
      b_store <= '0;
    end else if (i_ce) begin
      a_store <= next_a_store;
      b_store <= next_b_store;
    end
  end

  // ****************************************************************
  // Bus drivers
  // ****************************************************************
  ctrl_t ctrl, next_ctrl;
  bus_drive_t drive_a, drive_b, next_drive_a, next_drive_b;

  // Enables from enable and direction only; data from the selects
  always_comb begin
    next_drive_a.oe_n = ctrl.enable_n || ctrl.dir;
    next_drive_b.oe_n = ctrl.enable_n || !ctrl.dir;
    next_drive_a.data = ctrl.sel_ba ? b_store : b_live;
    next_drive_b.data = ctrl.sel_ab ? a_store : a_live;
  end

  // Registered pins: the mux never reaches a pin unsettled
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      drive_a <= '{data: '0, oe_n: 1'b1};
      drive_b <= '{data: '0, oe_n: 1'b1};
    end else if (i_ce) begin
      drive_a <= next_drive_a;
      drive_b <= next_drive_b;
    end
  end

  assign o_bus_a = drive_a.data;
  assign o_bus_a_oe_n = drive_a.oe_n;
  assign o_bus_b = drive_b.data;
  assign o_bus_b_oe_n = drive_b.oe_n;

  // ****************************************************************
  // Capture snapshot buffer
  // ****************************************************************
  cap_entry_t cap_in, cap_out;
  logic [CW-1:0] cap_out_bits;
  logic cap_push, cap_ready, cap_valid, cap_pop;

  // One snapshot per cycle with any capture edge
  always_comb begin
    cap_push = a_rise || b_rise;
    cap_in.a_new = a_rise;
    cap_in.b_new = b_rise;
    cap_in.a_data = next_a_store;
    cap_in.b_data = next_b_store;
  end

  xcvr_buffer #(.WIDTH(CW), .DEPTH(BUF_DEPTH)) u_cap_buffer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(cap_push),
    .i_in_data(cap_in),
    .o_in_ready(cap_ready),
    .o_out_valid(cap_valid),
    .o_out_data(cap_out_bits),
    .i_out_ready(cap_pop)
  );

  assign cap_out = cap_entry_t'(cap_out_bits);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_held, w_held, aw_ready, w_ready, bvalid, arready, rvalid;
  logic overflow, next_aw_held, next_w_held, next_bvalid, next_arready;
  logic next_rvalid, next_overflow, wr_go, rd_go;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;

  // Write, read and flag next values
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = ctrl;
    next_overflow = overflow;
    cap_pop = 1'b0;
    // Address and data taken in either order
    if (i_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = i_axi_wdata;
      next_w_strb = i_axi_wstrb;
    end
    wr_go = aw_held && w_held && !bvalid;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = `XCVR_RESP_OKAY;
      unique case (aw_addr)
        `XCVR_OFS_CTRL: begin
          if (w_strb[0]) begin
            next_ctrl = ctrl_t'(w_data[`XCVR_CTRL_SEL_BA:0]);
          end
        end
        `XCVR_OFS_STATUS: begin
          if (w_strb[0] && w_data[`XCVR_STAT_OVERFLOW]) begin
            next_overflow = 1'b0;
          end
        end
        `XCVR_OFS_STORE, `XCVR_OFS_CAPTURE: ; // Read-only, write ignored
        default: begin
          next_bresp = `XCVR_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid && i_axi_bready) begin
      next_bvalid = 1'b0;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    // Lost snapshot: set beats a same-cycle clear
    if (cap_push && !cap_ready) begin
      next_overflow = 1'b1;
    end
    // Read channel; a read of the capture word pops it
    rd_go = i_axi_arvalid && arready;
    if (rd_go) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = `XCVR_RESP_OKAY;
      unique case (i_axi_araddr)
        `XCVR_OFS_CTRL: begin
          next_rdata[`XCVR_CTRL_SEL_BA:0] = ctrl;
        end
        `XCVR_OFS_STORE: begin
          next_rdata[`XCVR_STORE_A_LSB +: DW] = a_store;
          next_rdata[`XCVR_STORE_B_LSB +: DW] = b_store;
        end
        `XCVR_OFS_CAPTURE: begin
          if (cap_valid) begin
            next_rdata[CW-1:0] = cap_out;
            next_rdata[`XCVR_CAP_VALID] = 1'b1;
            cap_pop = 1'b1;
          end
        end
        `XCVR_OFS_STATUS: begin
          next_rdata[`XCVR_STAT_OVERFLOW] = overflow;
          next_rdata[`XCVR_STAT_PENDING] = cap_valid;
        end
        default: begin
          next_rresp = `XCVR_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && i_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Slave registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `XCVR_RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `XCVR_RESP_OKAY;
      ctrl <= ctrl_t'(`XCVR_CTRL_RESET);
      overflow <= 1'b0;
    end else if (i_ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_ready <= !next_aw_held;
      w_ready <= !next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl <= next_ctrl;
      overflow <= next_overflow;
    end
  end

  // Ready flags come from their own flops
  assign o_axi_awready = aw_ready;
  assign o_axi_wready = w_ready;
  assign o_axi_bvalid = bvalid;
  assign o_axi_bresp = bresp;
  assign o_axi_arready = arready;
  assign o_axi_rvalid = rvalid;
  assign o_axi_rdata = rdata;
  assign o_axi_rresp = rresp;

endmodule : octal_bus_transceiver_register

`default_nettype wire

// *** tb/octal_bus_transceiver_register_sva.sv ***
`default_nettype none

`include "xcvr_params.svh"

module octal_bus_transceiver_register_sva (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Bus pins
  input wire logic i_a_capture_clock,
  input wire logic i_b_capture_clock,
  input wire logic [`XCVR_DATA_W-1:0] i_bus_a,
  input wire logic [`XCVR_DATA_W-1:0] i_bus_b,
  input wire logic [`XCVR_DATA_W-1:0] o_bus_a,
  input wire logic [`XCVR_DATA_W-1:0] o_bus_b,
  input wire logic o_bus_a_oe_n,
  input wire logic o_bus_b_oe_n,
  // Register bus handshakes
  input wire logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  // ****
  // Quiet counter: cycles since a write or capture
  // ****
  logic [3:0] quiet;
  logic [3:0] next_quiet;

  // Saturating count, cleared by any cause of change
  always_comb begin
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    if (o_axi_bvalid || i_a_capture_clock || i_b_capture_clock) begin
      next_quiet = 4'h0;
    end
  end

  // Register the count
  always_ff @(posedge i_core_clk) begin
    quiet <= i_rst_n ? next_quiet : 4'h0;
  end

  // ****
  // Assertions
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ONE_DRIVER: assert property (o_bus_a_oe_n || o_bus_b_oe_n)
    else $error("both buses driven at once");
  AST_ISO_RESET: assert property ($rose(i_rst_n) |->
    o_bus_a_oe_n && o_bus_b_oe_n)
    else $error("bus driven after reset");
  AST_OE_CAUSE: assert property (
    $changed(o_bus_a_oe_n) || $changed(o_bus_b_oe_n) |->
    !$past(i_rst_n) || ($past(o_axi_bvalid) && !$past(o_axi_bvalid, 2)))
    else $error("bus enable changed without control write");
  AST_LIVE_A2B: assert property (!o_bus_b_oe_n &&
    $stable(o_bus_b_oe_n) && quiet > 4'h5 && $changed(o_bus_b) |->
    o_bus_b == $past(i_bus_a, 3))
    else $error("bus b not live copy of bus a");
  AST_LIVE_B2A: assert property (!o_bus_a_oe_n &&
    $stable(o_bus_a_oe_n) && quiet > 4'h5 && $changed(o_bus_a) |->
    o_bus_a == $past(i_bus_b, 3))
    else $error("bus a not live copy of bus b");
  AST_RD_ANSWER: assert property (i_axi_arvalid && o_axi_arready |=>
    o_axi_rvalid && !o_axi_arready)
    else $error("read answer late");
  AST_RD_DONE: assert property (o_axi_rvalid && i_axi_rready |=>
    !o_axi_rvalid && o_axi_arready)
    else $error("read not closed");
  AST_WR_DONE: assert property (o_axi_bvalid && i_axi_bready |=>
    !o_axi_bvalid)
    else $error("write response not closed");

  // Main scenarios seen
  cover property (!o_bus_b_oe_n && $changed(o_bus_b));
  cover property (!o_bus_a_oe_n && $changed(o_bus_a));
  cover property ($rose(i_a_capture_clock) && $rose(i_b_capture_clock));
endmodule : octal_bus_transceiver_register_sva

bind octal_bus_transceiver_register octal_bus_transceiver_register_sva
  u_sva (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_a_capture_clock(i_a_capture_clock),
  .i_b_capture_clock(i_b_capture_clock),
  .i_bus_a(i_bus_a),
  .i_bus_b(i_bus_b),
  .o_bus_a(o_bus_a),
  .o_bus_b(o_bus_b),
  .o_bus_a_oe_n(o_bus_a_oe_n),
  .o_bus_b_oe_n(o_bus_b_oe_n),
  .o_axi_bvalid(o_axi_bvalid),
  .i_axi_bready(i_axi_bready),
  .i_axi_arvalid(i_axi_arvalid),
  .o_axi_arready(o_axi_arready),
  .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready)
);

`default_nettype wire

// *** tb/far_bus_model.sv ***
`default_nettype none

`include "xcvr_params.svh"

module far_bus_model (
  // Clock
  input wire logic i_core_clk,
  // Device drive
  input wire logic [`XCVR_DATA_W-1:0] i_dev_a,
  input wire logic [`XCVR_DATA_W-1:0] i_dev_b,
  input wire logic i_dev_a_oe_n,
  input wire logic i_dev_b_oe_n,
  // Far side values
  input wire logic [`XCVR_DATA_W-1:0] i_far_a,
  input wire logic [`XCVR_DATA_W-1:0] i_far_b,
  // Resolved levels and capture clocks
  output logic [`XCVR_DATA_W-1:0] o_wire_a,
  output logic [`XCVR_DATA_W-1:0] o_wire_b,
  output var logic o_cap_a,
  output var logic o_cap_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // Far side yields a bus while the device drives it
  assign o_wire_a = i_dev_a_oe_n ? i_far_a : i_dev_a;
  assign o_wire_b = i_dev_b_oe_n ? i_far_b : i_dev_b;

  // Capture clocks idle low
  initial begin
    o_cap_a = 1'b0;
    o_cap_b = 1'b0;
  end

  // Clocks move only on request, steady otherwise
  task pulse(input logic [1:0] which);
    @(posedge i_core_clk);
    {o_cap_b, o_cap_a} <= which;
    repeat (4) @(posedge i_core_clk);
    {o_cap_b, o_cap_a} <= 2'b00;
    repeat (4) @(posedge i_core_clk);
  endtask : pulse
endmodule : far_bus_model

`default_nettype wire

// *** tb/tb_octal_bus_transceiver_register.sv ***
`default_nettype none

module tb_octal_bus_transceiver_register;
  timeunit 1ns;
  timeprecision 1ns;
  import xcvr_pkg::*;

  logic clk = 1'b0;
  logic rst_n;
  logic [7:0] far_a, far_b, wire_a, wire_b, o_a, o_b;
  logic oe_a_n, oe_b_n, cap_a, cap_b;
  logic awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  int fail_count = 0;
  int samples_checked = 0;

  // Clock
  always #20 clk = ~clk;

  octal_bus_transceiver_register DUT (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_a_capture_clock(cap_a), .i_b_capture_clock(cap_b),
    .i_bus_a(wire_a), .o_bus_a(o_a), .o_bus_a_oe_n(oe_a_n),
    .i_bus_b(wire_b), .o_bus_b(o_b), .o_bus_b_oe_n(oe_b_n),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wv), .o_axi_wready(wr_r), .i_axi_wdata(wdata),
    .i_axi_wstrb(4'hF), .o_axi_bvalid(bv), .i_axi_bready(br),
    .o_axi_bresp(bresp), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .i_axi_araddr(araddr), .o_axi_rvalid(rv), .i_axi_rready(rr),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp));

  far_bus_model far (
    .i_core_clk(clk), .i_dev_a(o_a), .i_dev_b(o_b),
    .i_dev_a_oe_n(oe_a_n), .i_dev_b_oe_n(oe_b_n),
    .i_far_a(far_a), .i_far_b(far_b), .o_wire_a(wire_a),
    .o_wire_b(wire_b), .o_cap_a(cap_a), .o_cap_b(cap_b));

  // ****
  // Shared tasks
  // ****
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awv <= 1'b1; awaddr <= a; wv <= 1'b1; wdata <= d;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin ad = 1'b1; awv <= 1'b0; end
      if (!dd && wr_r === 1'b1) begin dd = 1'b1; wv <= 1'b0; end
    end
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    rsp = bresp;
    br <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    arv <= 1'b1; araddr <= a; rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rr <= 1'b0;
  endtask : rd_reg

  task print_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ****
  // Scenarios
  // ****
  task t_reset;
    check("oe pair", {30'h0, oe_b_n, oe_a_n}, 32'h3);
    rd_reg(8'h00); check("ctrl", rd, 32'h1);
    rd_reg(8'h04); check("store", rd, 32'h0);
    rd_reg(8'h10); check("unmapped resp", {30'h0, rsp}, 32'h2);
    check("unmapped data", rd, 32'h0);
  endtask : t_reset

  task t_isolated_capture;
    far_a <= 8'hA5; far_b <= 8'h3C;
    repeat (4) @(posedge clk);
    far.pulse(2'b11);
    rd_reg(8'h04); check("store", rd, 32'h3CA5);
    rd_reg(8'h08); check("snapshot", rd, 32'h80033CA5);
    rd_reg(8'h08); check("snapshot empty", rd, 32'h0);
  endtask : t_isolated_capture

  task t_fill_buffer;
    for (int i = 0; i < 3; i++) begin
      far_a <= 8'h10 + 8'(i);
      repeat (4) @(posedge clk);
      far.pulse(2'b01);
    end
    rd_reg(8'h0C); check("status full", rd, 32'h3);
    rd_reg(8'h08); check("first", rd, 32'h80013C10);
    rd_reg(8'h08); check("second", rd, 32'h80013C11);
    rd_reg(8'h08); check("drained", rd, 32'h0);
    wr(8'h0C, 32'h1);
    check("write resp", {30'h0, rsp}, 32'h0);
    rd_reg(8'h0C); check("status clear", rd, 32'h0);
    rd_reg(8'h04); check("store after drop", rd, 32'h3C12);
  endtask : t_fill_buffer

  task t_a_to_b;
    wr(8'h00, 32'h2);
    repeat (3) @(posedge clk);
    check("oe a to b", {30'h0, oe_b_n, oe_a_n}, 32'h1);
    far_a <= 8'h81;
    repeat (5) @(posedge clk);
    check("live b", {24'h0, o_b}, 32'h81);
    wr(8'h00, 32'h6);
    repeat (3) @(posedge clk);
    check("stored b", {24'h0, o_b}, 32'h12);
    check("oe with select", {30'h0, oe_b_n, oe_a_n}, 32'h1);
    far_a <= 8'h7E;
    repeat (5) @(posedge clk);
    check("stored b held", {24'h0, o_b}, 32'h12);
  endtask : t_a_to_b

  task t_b_to_a;
    logic ok;
    far_b <= 8'h5A;
    wr(8'h00, 32'h0);
    repeat (5) @(posedge clk);
    check("oe b to a", {30'h0, oe_b_n, oe_a_n}, 32'h2);
    check("live a", {24'h0, o_a}, 32'h5A);
    far_b <= 8'hC3;
    repeat (5) @(posedge clk);
    check("live a follows", {24'h0, o_a}, 32'hC3);
    fork
      wr(8'h00, 32'h8);
      repeat (8) begin
        @(posedge clk);
        #1 ok = (o_a === 8'hC3) || (o_a === 8'h3C);
        check("switch", {31'h0, ok}, 32'h1);
      end
    join
    check("stored a", {24'h0, o_a}, 32'h3C);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge clk);
    check("isolated", {30'h0, oe_b_n, oe_a_n}, 32'h3);
  endtask : t_b_to_a

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    far_a = 8'h00; far_b = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_isolated_capture;
    t_fill_buffer;
    t_a_to_b;
    t_b_to_a;
    print_verdict;
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule : tb_octal_bus_transceiver_register

`default_nettype wire
